// [logic/dmrx_core.sv]
// receive write control, regfile arbiter, engine status and interrupt logic
// assumes the stream source and port state machine run on mclk; byte shifter lives elsewhere

////////////////////////////////////////////////////////////////////////////////
module dmrx_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	// clock and control
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic do_wr;
	logic do_rd;

	assign in_ready = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];
	assign do_wr = ce && in_valid && in_ready;
	assign do_rd = ce && out_ready && out_valid;

	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count_ff <= count_ff + 1'b1;
			end else if (do_rd && !do_wr) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Function
// - footer: no padding, exactly eight words
// - ack and byte enables per word, pads included
// - header words discarded, ready held until payload start
// - wait payload-idle until burst start command
// - stay in transfer until 32 words pushed
// - after end and drain, cache-line start enters footer
// - footer first three words byte enables low
// - at most one of five requesters granted
// - control bus wins; grant only when not busy
// - engines round-robin, last grant resets write1
// - control bus grant leaves last engine untouched
// - status bits 0-6, bit 7 reserved, 24 application
// - error sticky until system or channel reset
// - error on busy write, bad pointer, completed
// - five bits load from bus write or descriptor
// - completed set when descriptor data processed
// - receive engine sets first/last on stream markers
// - busy set by pointer write, cleared on end
// - interrupt shown only with master enable
// - pending flags rx1 tx1 rx0 tx0 at 28-31
// - pending set after write-back with interrupt-on-end
// - up/down counter drives interrupt detect output
module dmrx_core
	import dmrx_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int CNT_W = IRQ_CNT_W
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// receive stream
	input wire logic [31:0] rx_data,
	input wire logic rx_src_rdy,
	input wire logic payload_start_marker,
	input wire logic payload_end_marker,
	output logic rx_dst_rdy,
	// port state machine commands
	input wire logic rx_stream_start_cmd,
	input wire logic burst_start_cmd,
	input wire logic cache_line_start_cmd,
	input wire logic rx_engine_sel,
	input wire logic [4:0] burst_lead_pad,
	input wire logic [3:0] burst_last_be,
	output logic rx_pay_idle,
	output logic rx_pay_done,
	// memory write fifo side
	output logic write_ack_even,
	output logic write_ack_odd,
	output logic [3:0] write_byte_en_even,
	output logic [3:0] write_byte_en_odd,
	output logic [31:0] write_data,
	// regfile arbitration: read0, read1, write0, write1
	input wire logic [3:0] eng_req,
	output logic [3:0] eng_gnt,
	// engine events, index tx0, rx0, tx1, rx1
	input wire logic [3:0] chan_rst,
	input wire logic [3:0] desc_stat_load,
	input wire logic [31:0] desc_stat_word,
	input wire logic [3:0] cmp_check_en,
	input wire logic [3:0] desc_done,
	input wire logic [3:0] desc_null_next,
	input wire logic [3:0] err_event,
	input wire logic [3:0] wb_done,
	// control bus
	input wire logic cb_req,
	input wire logic cb_we,
	input wire logic [3:0] cb_sel,
	input wire logic [31:0] cb_wdata,
	output logic cb_ack,
	output logic [31:0] cb_rdata,
	// interrupt
	output logic irq_detect
);
	dmrx_state_t state_ff;
	dmrx_state_t nxt_state;
	logic [4:0] word_cnt_ff;
	logic [4:0] lead_pad_ff;
	logic [3:0] last_be_ff;
	logic [3:0] foot_in_ff;
	logic eop_seen_ff;
	logic odd_ff;
	logic accept_en;
	logic take;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [32:0] fifo_out_data;
	logic pop;
	logic push;
	logic [3:0] push_be;
	logic [31:0] push_data;
	logic [1:0] rx_eng;
	logic sop_seen;
	logic eop_take;

	////////////////////////////////////////////////////////////////////////////////
	// receive stream intake
	assign rx_eng = {rx_engine_sel, 1'b1};
	assign accept_en = ((state_ff == RX_PAY_IDLE || state_ff == RX_PAY_XFER) && !eop_seen_ff) ||
		(state_ff == RX_FOOTER && foot_in_ff != FOOTER_IN_WORDS);
	assign take = ce && rx_src_rdy && rx_dst_rdy && accept_en;
	assign sop_seen = ce && state_ff == RX_HEADER && rx_src_rdy && payload_start_marker;
	assign eop_take = take && state_ff != RX_FOOTER && payload_end_marker;

	always_comb begin
		if (state_ff == RX_HEADER) begin
			rx_dst_rdy = ce && !payload_start_marker;
		end else begin
			rx_dst_rdy = ce && accept_en && fifo_in_ready;
		end
	end

	// the marker word stays on the stream in header and is consumed as payload
	dmrx_fifo #(.WIDTH(33), .DEPTH(DEPTH)) u_fifo (
		.mclk(mclk),
		.srst(srst),
		.ce(ce),
		.in_valid(rx_src_rdy && accept_en),
		.in_ready(fifo_in_ready),
		.in_data({payload_end_marker && state_ff != RX_FOOTER, rx_data}),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// drain toward the write fifos, pads carry no byte enables
	always_comb begin
		pop = 1'b0;
		push = 1'b0;
		push_be = BE_NONE;
		push_data = fifo_out_data[31:0];
		if (state_ff == RX_PAY_XFER) begin
			if (word_cnt_ff < lead_pad_ff) begin
				push = 1'b1;
			end else if (fifo_out_valid) begin
				pop = 1'b1;
				push = 1'b1;
				push_be = fifo_out_data[32] ? last_be_ff : BE_ALL;
			end else if (eop_seen_ff) begin
				push = 1'b1;
			end
		end else if (state_ff == RX_FOOTER && fifo_out_valid) begin
			pop = 1'b1;
			push = 1'b1;
			push_be = (word_cnt_ff < FOOTER_KEEP) ? BE_NONE : BE_ALL;
		end
	end

	assign rx_pay_idle = (state_ff == RX_PAY_IDLE);
	assign rx_pay_done = (state_ff == RX_PAY_IDLE) && eop_seen_ff && !fifo_out_valid;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			RX_IDLE: begin
				if (rx_stream_start_cmd) begin
					nxt_state = RX_HEADER;
				end
			end
			RX_HEADER: begin
				if (rx_src_rdy && payload_start_marker) begin
					nxt_state = RX_PAY_IDLE;
				end
			end
			RX_PAY_IDLE: begin
				if (rx_pay_done && cache_line_start_cmd) begin
					nxt_state = RX_FOOTER;
				end else if (!rx_pay_done && burst_start_cmd) begin
					nxt_state = RX_PAY_XFER;
				end
			end
			RX_PAY_XFER: begin
				if (push && word_cnt_ff == BURST_LAST) begin
					nxt_state = RX_PAY_IDLE;
				end
			end
			RX_FOOTER: begin
				if (push && word_cnt_ff == FOOTER_LAST) begin
					nxt_state = RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_ff <= RX_IDLE;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			word_cnt_ff <= '0;
			odd_ff <= 1'b0;
		end else if (ce) begin
			if (state_ff != nxt_state) begin
				word_cnt_ff <= '0;
				odd_ff <= 1'b0;
			end else if (push) begin
				word_cnt_ff <= word_cnt_ff + 1'b1;
				odd_ff <= !odd_ff;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			lead_pad_ff <= '0;
			last_be_ff <= BE_ALL;
			eop_seen_ff <= 1'b0;
			foot_in_ff <= '0;
		end else if (ce) begin
			if (state_ff == RX_PAY_IDLE && nxt_state == RX_PAY_XFER) begin
				lead_pad_ff <= burst_lead_pad;
				last_be_ff <= burst_last_be;
			end
			if (state_ff == RX_IDLE) begin
				eop_seen_ff <= 1'b0;
				foot_in_ff <= '0;
			end else begin
				if (eop_take) begin
					eop_seen_ff <= 1'b1;
				end
				if (take && state_ff == RX_FOOTER) begin
					foot_in_ff <= foot_in_ff + 1'b1;
				end
			end
		end
	end

	// registered write side, even and odd alternate from each burst's start
	always_ff @(posedge mclk) begin
		if (srst) begin
			write_ack_even <= 1'b0;
			write_ack_odd <= 1'b0;
			write_byte_en_even <= BE_NONE;
			write_byte_en_odd <= BE_NONE;
			write_data <= '0;
		end else if (ce) begin
			write_ack_even <= push && !odd_ff;
			write_ack_odd <= push && odd_ff;
			if (push && !odd_ff) begin
				write_byte_en_even <= push_be;
			end
			if (push && odd_ff) begin
				write_byte_en_odd <= push_be;
			end
			if (push) begin
				write_data <= push_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// regfile arbiter
	logic rf_busy_ff;
	logic [1:0] last_ff;
	logic cb_gnt;
	logic [1:0] pick;
	logic pick_ok;

	assign cb_gnt = ce && cb_req && !rf_busy_ff;

	always_comb begin
		logic [1:0] idx;
		idx = last_ff;
		pick = last_ff;
		pick_ok = 1'b0;
		for (int i = 0; i < ENG_NUM; i++) begin
			idx = idx + 1'b1;
			if (!pick_ok && eng_req[idx]) begin
				pick = idx;
				pick_ok = 1'b1;
			end
		end
	end

	always_comb begin
		eng_gnt = '0;
		if (ce && !rf_busy_ff && !cb_req && pick_ok) begin
			eng_gnt[pick] = 1'b1;
		end
	end

	// one idle cycle after each grant keeps accesses atomic
	always_ff @(posedge mclk) begin
		if (srst) begin
			rf_busy_ff <= 1'b0;
			last_ff <= LAST_GRANT_RST;
		end else if (ce) begin
			rf_busy_ff <= cb_gnt || (eng_gnt != '0);
			if (eng_gnt != '0) begin
				last_ff <= pick;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// engine status words and current pointers
	logic [31:0] stat_ff [ENG_NUM];
	logic [31:0] cptr_ff [ENG_NUM];
	logic [31:0] irq_ff;
	logic [3:0] irq_set;
	logic [3:0] irq_clr;
	logic [CNT_W-1:0] irq_cnt_ff;

	genvar e;
	generate
		for (e = 0; e < ENG_NUM; e++) begin : g_eng
			logic [31:0] nxt_stat;
			logic st_wr;
			logic cp_wr;
			assign st_wr = cb_gnt && cb_we && cb_sel == SEL_STAT0 + 4'(e);
			assign cp_wr = cb_gnt && cb_we && cb_sel == SEL_CPTR0 + 4'(e);
			always_comb begin
				nxt_stat = stat_ff[e];
				if (st_wr) begin
					nxt_stat = (stat_ff[e] & ~ST_LOAD_MASK) | (cb_wdata & ST_LOAD_MASK);
				end
				if (desc_stat_load[e]) begin
					nxt_stat = (stat_ff[e] & ~ST_LOAD_MASK) | (desc_stat_word & ST_LOAD_MASK);
					if (cmp_check_en[e] && desc_stat_word[ST_CMP]) begin
						nxt_stat[ST_ERR] = 1'b1;
					end
				end
				if (desc_done[e]) begin
					nxt_stat[ST_CMP] = 1'b1;
					if (nxt_stat[ST_SOE] || desc_null_next[e]) begin
						nxt_stat[ST_BSY] = 1'b0;
					end
				end
				if (cp_wr) begin
					if (stat_ff[e][ST_BSY]) begin
						nxt_stat[ST_ERR] = 1'b1;
					end else begin
						nxt_stat[ST_BSY] = 1'b1;
					end
				end
				if (err_event[e]) begin
					nxt_stat[ST_ERR] = 1'b1;
				end
				if (stat_ff[e][ST_ERR]) begin
					nxt_stat[ST_ERR] = 1'b1;
				end
				if (nxt_stat[ST_ERR]) begin
					nxt_stat[ST_BSY] = 1'b0;
				end
				if (sop_seen && rx_eng == 2'(e)) begin
					nxt_stat[ST_PKF] = 1'b1;
				end
				if (eop_take && rx_eng == 2'(e)) begin
					nxt_stat[ST_PKL] = 1'b1;
				end
				nxt_stat[ST_RSV] = 1'b0;
			end
			always_ff @(posedge mclk) begin
				if (srst || (ce && chan_rst[e])) begin
					stat_ff[e] <= ST_RESET;
				end else if (ce) begin
					stat_ff[e] <= nxt_stat;
				end
			end
			always_ff @(posedge mclk) begin
				if (srst) begin
					cptr_ff[e] <= '0;
				end else if (ce && cp_wr) begin
					cptr_ff[e] <= cb_wdata;
				end
			end
			assign irq_set[e] = ce && wb_done[e] && stat_ff[e][ST_IOE];
			assign irq_clr[e] = cb_gnt && cb_we && cb_sel == SEL_IRQ && cb_wdata[e] && irq_ff[e];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// interrupt control word and outstanding count
	logic [CNT_W-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = irq_cnt_ff;
		for (int i = 0; i < ENG_NUM; i++) begin
			if (irq_set[i]) begin
				nxt_cnt = nxt_cnt + 1'b1;
			end
			if (irq_clr[i] && !irq_set[i]) begin
				nxt_cnt = nxt_cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_ff <= IRQ_RESET;
			irq_cnt_ff <= '0;
			irq_detect <= 1'b0;
		end else if (ce) begin
			if (cb_gnt && cb_we && cb_sel == SEL_IRQ) begin
				irq_ff[IRQ_MEN] <= cb_wdata[IRQ_MEN];
			end
			irq_ff[3:0] <= (irq_ff[3:0] & ~irq_clr) | irq_set;
			irq_cnt_ff <= nxt_cnt;
			irq_detect <= irq_ff[IRQ_MEN] && (nxt_cnt != '0);
		end
	end

	// control bus read answer, one cycle after the grant
	always_ff @(posedge mclk) begin
		if (srst) begin
			cb_ack <= 1'b0;
			cb_rdata <= '0;
		end else if (ce) begin
			cb_ack <= cb_gnt;
			if (cb_gnt) begin
				if (cb_sel < SEL_CPTR0) begin
					cb_rdata <= stat_ff[cb_sel[1:0]];
				end else if (cb_sel < SEL_IRQ) begin
					cb_rdata <= cptr_ff[cb_sel[1:0]];
				end else if (cb_sel == SEL_IRQ) begin
					cb_rdata <= irq_ff;
				end else begin
					cb_rdata <= '0;
				end
			end
		end
	end
endmodule

// [logic/dmrx_pkg.sv]
// constants shared by the receive write control, regfile arbiter and status logic
// assumes one clock, synchronous active-high reset, 32-bit control words
package dmrx_pkg;
	localparam int ENG_NUM = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int IRQ_CNT_W = 4;

	// receive burst and footer shape
	localparam logic [4:0] BURST_LAST = 5'h1f;
	localparam logic [4:0] FOOTER_LAST = 5'h07;
	localparam logic [4:0] FOOTER_KEEP = 5'h03;
	localparam logic [3:0] FOOTER_IN_WORDS = 4'h8;
	localparam logic [3:0] BE_ALL = 4'hf;
	localparam logic [3:0] BE_NONE = 4'h0;

	// engine status word: status bit n sits at vector bit 31-n
	localparam int ST_ERR = 31;
	localparam int ST_IOE = 30;
	localparam int ST_SOE = 29;
	localparam int ST_CMP = 28;
	localparam int ST_PKF = 27;
	localparam int ST_PKL = 26;
	localparam int ST_BSY = 25;
	localparam int ST_RSV = 24;
	localparam int APP_MSB = 23;
	localparam logic [31:0] ST_RESET = 32'h0000_0000;
	localparam logic [31:0] ST_LOAD_MASK = 32'h7cff_ffff;

	// interrupt control word: master enable at bit 0 (vector 31), pending at 28..31
	localparam int IRQ_MEN = 31;
	localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

	// control bus register select
	localparam logic [3:0] SEL_STAT0 = 4'h0;
	localparam logic [3:0] SEL_CPTR0 = 4'h4;
	localparam logic [3:0] SEL_IRQ = 4'h8;

	// engine index: 0 tx0, 1 rx0, 2 tx1, 3 rx1; arbiter index: read0, read1, write0, write1
	localparam logic [1:0] LAST_GRANT_RST = 2'h3;

	typedef enum logic [2:0] {
		RX_IDLE,
		RX_HEADER,
		RX_PAY_IDLE,
		RX_PAY_XFER,
		RX_FOOTER
	} dmrx_state_t;
endpackage

// [sim/dmrx_core_props.sv]
// port checker for the receive write control and the regfile arbiter
// assumes it is bound into dmrx_core, one clock, synchronous reset
module dmrx_core_props
	import dmrx_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// receive commands and state
	input wire logic burst_start_cmd,
	input wire logic cache_line_start_cmd,
	input wire logic rx_pay_idle,
	input wire logic rx_pay_done,
	// write fifo side
	input wire logic write_ack_even,
	input wire logic write_ack_odd,
	input wire logic [3:0] write_byte_en_even,
	input wire logic [3:0] write_byte_en_odd,
	// arbitration
	input wire logic [3:0] eng_req,
	input wire logic [3:0] eng_gnt,
	input wire logic cb_req,
	input wire logic cb_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);

	logic [5:0] acnt_ff;
	logic inb_ff;
	logic ft_ff;
	logic ack_any;
	assign ack_any = write_ack_even || write_ack_odd;

	////////////////////////////////////////////////////////////////////////////////
	// acks counted from each burst or footer start, so parity and totals are judged per unit
	always_ff @(posedge mclk) begin
		if (srst || (burst_start_cmd && rx_pay_idle) || (cache_line_start_cmd && rx_pay_done)) begin
			acnt_ff <= 6'h00;
		end else if (ack_any) begin
			acnt_ff <= acnt_ff + 6'h01;
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			inb_ff <= 1'b0;
		end else if (rx_pay_idle) begin
			inb_ff <= burst_start_cmd;
		end
	end
	always_ff @(posedge mclk) begin
		if (srst || burst_start_cmd) begin
			ft_ff <= 1'b0;
		end else if (cache_line_start_cmd && rx_pay_done) begin
			ft_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_gnt_single: assert property (eng_gnt != 4'h0 |-> $onehot(eng_gnt) && !cb_req ##1 eng_gnt == 4'h0)
		else $error("engine grant not one-hot, not spaced or beside a bus request");
	a_eng_served: assert property (eng_req != 4'h0 && !cb_req |-> eng_gnt != 4'h0 || $past(eng_gnt) != 4'h0 || cb_ack)
		else $error("engine request left waiting while regfile idle");
	a_cb_answer: assert property (cb_req && !cb_ack |-> ##[1:2] cb_ack)
		else $error("control bus request not answered in time");
	a_ack_parity: assert property (ack_any |-> write_ack_odd == acnt_ff[0] && !(write_ack_even && write_ack_odd))
		else $error("write acks not alternating from even");
	a_burst_count: assert property (inb_ff && rx_pay_idle |-> ##[1:2] acnt_ff == 6'h20)
		else $error("burst did not push thirty-two words");
	a_pay_wait: assert property (rx_pay_idle && !burst_start_cmd && !cache_line_start_cmd |=> rx_pay_idle)
		else $error("payload idle left without a command");
	a_footer_enter: assert property (cache_line_start_cmd && rx_pay_done |=> !rx_pay_idle && !rx_pay_done)
		else $error("cache line start did not enter footer");
	a_footer_be: assert property (ft_ff && ack_any |->
		(write_ack_odd ? write_byte_en_odd : write_byte_en_even) == (acnt_ff < 6'h03 ? BE_NONE : BE_ALL))
		else $error("footer byte enables wrong");
	a_footer_bound: assert property (ft_ff |-> acnt_ff <= 6'h08)
		else $error("footer pushed more than eight words");
endmodule

bind dmrx_core dmrx_core_props u_props (.mclk, .srst, .burst_start_cmd, .cache_line_start_cmd, .rx_pay_idle,
	.rx_pay_done, .write_ack_even, .write_ack_odd, .write_byte_en_even, .write_byte_en_odd, .eng_req, .eng_gnt,
	.cb_req, .cb_ack);

// [sim/dmrx_src_model.sv]
// stream source in front of the receive port
// assumes the bench fills q with {start, end, data} and sets the stall percentage
module dmrx_src_model (
	// clock
	input wire logic mclk,
	// receive stream
	input wire logic rx_dst_rdy,
	output logic [31:0] rx_data,
	output logic rx_src_rdy,
	output logic payload_start_marker,
	output logic payload_end_marker
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [33:0] q[$];
	logic took = 1'b0;
	int slow = 0;

	initial begin
		rx_data = 32'h0000_0000;
		{payload_start_marker, payload_end_marker, rx_src_rdy} = 3'b000;
	end
	always @(posedge mclk) begin
		took = rx_src_rdy && rx_dst_rdy;
	end
	// a word stays up until taken; stalls fall only between words
	always @(negedge mclk) begin
		if (took) begin
			void'(q.pop_front());
		end
		if (q.size() > 0 && ((rx_src_rdy && !took) || $urandom_range(99) >= slow)) begin
			{payload_start_marker, payload_end_marker, rx_data} = q[0];
			rx_src_rdy = 1'b1;
		end else begin
			// released data must not pass for the last word
			{payload_start_marker, payload_end_marker, rx_src_rdy} = 3'b000;
			rx_data = ~rx_data;
		end
	end
endmodule

// [sim/testbench.sv]
// self-checking bench for receive write control, arbiter, status and interrupt logic
// assumes dmrx_src_model feeds the stream and all runs on mclk
module testbench
	import dmrx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, srst, ce, rx_src_rdy, payload_start_marker, payload_end_marker, rx_dst_rdy, rx_engine_sel;
	logic rx_stream_start_cmd, burst_start_cmd, cache_line_start_cmd, rx_pay_idle, rx_pay_done;
	logic write_ack_even, write_ack_odd, cb_req, cb_we, cb_ack, irq_detect;
	logic [31:0] rx_data, write_data, desc_stat_word, cb_wdata, cb_rdata, w;
	logic [31:0] pay[6], fw[8];
	logic [4:0] burst_lead_pad;
	logic [3:0] burst_last_be, write_byte_en_even, write_byte_en_odd, eng_req, eng_gnt, cb_sel, be;
	logic [3:0] chan_rst, desc_stat_load, cmp_check_en, desc_done, desc_null_next, err_event, wb_done;
	logic [36:0] obs[$], exq[$];
	int err_total = 0, compares = 0, last_gnt = 3, i, nx;

	dmrx_src_model src (.mclk, .rx_dst_rdy, .rx_data, .rx_src_rdy, .payload_start_marker, .payload_end_marker);
	dmrx_core uut (.mclk, .srst, .ce, .rx_data, .rx_src_rdy, .payload_start_marker, .payload_end_marker,
		.rx_dst_rdy, .rx_stream_start_cmd, .burst_start_cmd, .cache_line_start_cmd, .rx_engine_sel,
		.burst_lead_pad, .burst_last_be, .rx_pay_idle, .rx_pay_done, .write_ack_even, .write_ack_odd,
		.write_byte_en_even, .write_byte_en_odd, .write_data, .eng_req, .eng_gnt, .chan_rst, .desc_stat_load,
		.desc_stat_word, .cmp_check_en, .desc_done, .desc_null_next, .err_event, .wb_done, .cb_req, .cb_we,
		.cb_sel, .cb_wdata, .cb_ack, .cb_rdata, .irq_detect);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("errors=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic await(input logic want_done, input int lim);
		for (int n = 0; n < lim && (want_done ? rx_pay_done : rx_pay_idle) !== 1'b1; n++) tick(1);
		if ((want_done ? rx_pay_done : rx_pay_idle) !== 1'b1) begin
			err_total++;
			results();
		end
	endtask
	// request held until the edge that samples the ack
	task automatic cb(input logic we, input logic [3:0] sel, input logic [31:0] wd, input logic [31:0] exp);
		int n;
		tick(1);
		{cb_req, cb_we, cb_sel, cb_wdata} = {1'b1, we, sel, wd};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (cb_ack !== 1'b1 && n < 20);
		if (cb_ack !== 1'b1) begin
			err_total++;
			results();
		end
		if (!we) chk(cb_rdata, exp);
		tick(1);
		cb_req = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// reference for the arbiter and the write fifo side
	always @(posedge mclk) begin
		if (write_ack_even || write_ack_odd) begin
			obs.push_back({write_ack_odd, write_ack_odd ? write_byte_en_odd : write_byte_en_even, write_data});
		end
		if (eng_gnt != 4'h0) begin
			nx = last_gnt;
			do nx = (nx + 1) % 4; while (eng_req[nx] !== 1'b1 && nx != last_gnt);
			chk(32'(eng_gnt), 32'h1 << nx);
			last_gnt = nx;
		end
	end

	initial begin
		{srst, ce, rx_engine_sel, cb_req, cb_we, cb_sel, cb_wdata, desc_stat_word} = {2'b11, 71'h0};
		{rx_stream_start_cmd, burst_start_cmd, cache_line_start_cmd, eng_req, chan_rst, desc_stat_load} = '0;
		{cmp_check_en, desc_done, desc_null_next, err_event, wb_done} = '0;
		burst_lead_pad = 5'h02;
		burst_last_be = 4'h7;
		void'($urandom(32'hcc4a_37f4));
		tick(12);
		srst = 1'b0;
		for (i = 0; i < 16; i++) begin
			if (i < 4 || i > 7) cb(1'b0, 4'(i), 32'h0, 32'h0);
		end
		// status word: bus load, busy, error on busy write, sticky error, channel reset
		w = $urandom();
		cb(1'b1, 4'h2, w, 32'h0);
		cb(1'b0, 4'h2, 32'h0, w & 32'h7cff_ffff);
		cb(1'b1, 4'h6, w, 32'h0);
		cb(1'b0, 4'h2, 32'h0, w & 32'h7cff_ffff | 32'h0200_0000);
		cb(1'b0, 4'h6, 32'h0, w);
		cb(1'b1, 4'h6, w, 32'h0);
		cb(1'b0, 4'h2, 32'h0, w & 32'h7cff_ffff | 32'h8000_0000);
		cb(1'b1, 4'h2, 32'hffff_ffff, 32'h0);
		cb(1'b0, 4'h2, 32'h0, 32'hfcff_ffff);
		tick(1);
		chan_rst = 4'h4;
		tick(1);
		chan_rst = 4'h0;
		cb(1'b0, 4'h2, 32'h0, 32'h0);
		// descriptor load with stop-on-end, then completion
		desc_stat_word = $urandom() | 32'h2000_0000;
		desc_stat_load = 4'h4;
		tick(1);
		desc_stat_load = 4'h0;
		cb(1'b1, 4'h6, 32'h0, 32'h0);
		tick(1);
		desc_done = 4'h4;
		tick(1);
		desc_done = 4'h0;
		cb(1'b0, 4'h2, 32'h0, desc_stat_word & 32'h6cff_ffff | 32'h1000_0000);
		// completed-check error, null next pointer ending busy, raw error event
		desc_stat_word = 32'h1000_0000;
		{cmp_check_en, desc_stat_load} = 8'h88;
		tick(1);
		desc_stat_load = 4'h0;
		cb(1'b0, 4'h3, 32'h0, 32'h9000_0000);
		chan_rst = 4'h8;
		tick(1);
		chan_rst = 4'h0;
		cb(1'b1, 4'h7, 32'h0, 32'h0);
		desc_null_next = 4'h8;
		desc_done = 4'h8;
		tick(1);
		desc_done = 4'h0;
		cb(1'b0, 4'h3, 32'h0, 32'h1000_0000);
		err_event = 4'h8;
		tick(1);
		err_event = 4'h0;
		{cmp_check_en, desc_null_next} = 8'h00;
		cb(1'b0, 4'h3, 32'h0, 32'h9000_0000);
		// interrupt with and without master enable
		cb(1'b1, 4'h0, 32'h4000_0000, 32'h0);
		for (i = 0; i < 2; i++) begin
			cb(1'b1, SEL_IRQ, i == 0 ? 32'h8000_0000 : 32'h0, 32'h0);
			tick(1);
			wb_done = 4'h1;
			tick(1);
			wb_done = 4'h0;
			tick(2);
			chk(32'(irq_detect), i == 0 ? 32'h1 : 32'h0);
			cb(1'b0, SEL_IRQ, 32'h0, i == 0 ? 32'h8000_0001 : 32'h1);
			cb(1'b1, SEL_IRQ, i == 0 ? 32'h8000_0001 : 32'h1, 32'h0);
			tick(2);
			chk(32'(irq_detect), 32'h0);
		end
		// frozen clock enable: a write-back event must leave no trace
		ce = 1'b0;
		wb_done = 4'h1;
		tick(2);
		wb_done = 4'h0;
		ce = 1'b1;
		chk(32'(irq_detect), 32'h0);
		cb(1'b0, SEL_IRQ, 32'h0, 32'h0);
		// random engine requests with a bus read cutting in
		fork
			for (int k = 0; k < 40; k++) begin
				tick(1);
				eng_req = 4'($urandom());
			end
			begin
				tick(9);
				cb(1'b0, 4'h0, 32'h0, 32'h4000_0000);
			end
		join
		tick(1);
		eng_req = 4'h0;
		// stream: header, payload, burst with lead and tail pads, footer
		src.slow = 30;
		for (i = 0; i < 8; i++) fw[i] = $urandom();
		for (i = 0; i < 3; i++) src.q.push_back({2'b00, 32'($urandom())});
		for (i = 0; i < 6; i++) begin
			pay[i] = $urandom();
			src.q.push_back({i == 0, i == 5, pay[i]});
		end
		for (i = 0; i < 40; i++) begin
			be = i > 34 ? 4'hf : (i > 31 ? 4'h0 : (i == 7 ? 4'h7 : (i > 1 && i < 8 ? 4'hf : 4'h0)));
			exq.push_back({i[0], be, i > 31 ? fw[i - 32] : pay[i - 2]});
		end
		rx_stream_start_cmd = 1'b1;
		tick(1);
		rx_stream_start_cmd = 1'b0;
		await(1'b0, 200);
		burst_start_cmd = 1'b1;
		tick(1);
		burst_start_cmd = 1'b0;
		await(1'b1, 400);
		tick(3);
		for (i = 0; i < 8; i++) src.q.push_back({2'b00, fw[i]});
		cache_line_start_cmd = 1'b1;
		tick(1);
		cache_line_start_cmd = 1'b0;
		for (i = 0; i < 300 && obs.size() < 40; i++) tick(1);
		tick(20);
		chk(32'(obs.size()), 32'h28);
		for (i = 0; i < 40 && i < obs.size(); i++) begin
			chk(32'(obs[i][36:32]), 32'(exq[i][36:32]));
			if (exq[i][35:32] != 4'h0 || i > 31) chk(obs[i][31:0], exq[i][31:0]);
		end
		cb(1'b0, 4'h1, 32'h0, 32'h0c00_0000);
		results();
	end
endmodule
